// ==== hw/sxa_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module sxa_alu #(
  parameter int unsigned DEPTH = sxa_pkg::FILE_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] ACC_OUT,
  output var sxa_pkg::sxa_flags_t FLAGS_OUT
);

  typedef struct packed {
    logic [7:0] acc;
    sxa_pkg::sxa_flags_t flags;
    logic [6:0] fidx;
    sxa_pkg::sxa_cmd_t cmd;
    logic [31:0] rdata;
    logic err;
    logic [DEPTH-1:0][7:0] files;
  } sxa_state_t;

  sxa_state_t st_q;
  sxa_state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic setup;
  logic wr_access;
  logic exec;
  logic mapped;
  sxa_pkg::sxa_cmd_t cmd_w;
  sxa_pkg::sxa_sub_res_t sub_res;
  logic [7:0] file_val;
  logic [7:0] sub_lhs;
  logic [7:0] result;
  logic result_valid;
  logic to_file;
  logic upd_zero;
  logic upd_carry;

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // bus phase decode; a command write runs in its access cycle
  assign setup = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign cmd_w = sxa_pkg::sxa_cmd_t'(PWDATA);
  assign exec = wr_access && (PADDR == sxa_pkg::ADDR_CMD);
  assign file_val = st_q.files[cmd_w.faddr];
  assign mapped = (PADDR == sxa_pkg::ADDR_ACC)
                  || (PADDR == sxa_pkg::ADDR_STATUS)
                  || (PADDR == sxa_pkg::ADDR_CMD)
                  || (PADDR == sxa_pkg::ADDR_FILE_IDX)
                  || (PADDR == sxa_pkg::ADDR_FILE_DATA);

  // the literal subtract and the register subtract share one subtractor
  assign sub_lhs = (cmd_w.op == sxa_pkg::OP_LITERAL_SUBTRACT)
                   ? cmd_w.literal : file_val;

  sxa_sub8 u_sub (
    .minuend(sub_lhs),
    .subtrahend(st_q.acc),
    .res(sub_res)
  );

  // operation select: result, where it goes, which flags move
  always_comb
  begin
    result = st_q.acc;
    result_valid = 1'b0;
    to_file = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    case (cmd_w.op)
      sxa_pkg::OP_LITERAL_SUBTRACT:
      begin
        result = sub_res.diff;
        result_valid = 1'b1;
        upd_zero = 1'b1;
        upd_carry = 1'b1;
      end
      sxa_pkg::OP_REGISTER_SUBTRACT:
      begin
        result = sub_res.diff;
        result_valid = 1'b1;
        to_file = (cmd_w.dest == sxa_pkg::DEST_FILE);
        upd_zero = 1'b1;
        upd_carry = 1'b1;
      end
      sxa_pkg::OP_LITERAL_EXCLUSIVE_OR:
      begin
        result = st_q.acc ^ cmd_w.literal;
        result_valid = 1'b1;
        upd_zero = 1'b1;
      end
      sxa_pkg::OP_REGISTER_EXCLUSIVE_OR:
      begin
        result = st_q.acc ^ file_val;
        result_valid = 1'b1;
        to_file = (cmd_w.dest == sxa_pkg::DEST_FILE);
        upd_zero = 1'b1;
      end
      sxa_pkg::OP_NIBBLE_EXCHANGE:
      begin
        result = {file_val[3:0], file_val[7:4]};
        result_valid = 1'b1;
        to_file = (cmd_w.dest == sxa_pkg::DEST_FILE);
      end
      default:
      begin
        result = st_q.acc; // idle or unknown code: nothing moves
      end
    endcase
  end

  // next state: bus reads are captured in setup so data comes from flops
  always_comb
  begin
    st_d = st_q;
    if (setup)
    begin
      st_d.err = !mapped;
      case (PADDR)
        sxa_pkg::ADDR_ACC: st_d.rdata = {24'h00_0000, st_q.acc};
        sxa_pkg::ADDR_STATUS: st_d.rdata = {29'h0, st_q.flags};
        sxa_pkg::ADDR_CMD: st_d.rdata = st_q.cmd;
        sxa_pkg::ADDR_FILE_IDX: st_d.rdata = {25'h0, st_q.fidx};
        sxa_pkg::ADDR_FILE_DATA:
          st_d.rdata = {24'h00_0000, st_q.files[st_q.fidx]};
        default: st_d.rdata = sxa_pkg::RDATA_RESET;
      endcase
    end
    if (wr_access)
    begin
      case (PADDR)
        sxa_pkg::ADDR_ACC: st_d.acc = PWDATA[7:0];
        sxa_pkg::ADDR_STATUS: st_d.flags = sxa_pkg::sxa_flags_t'(PWDATA[2:0]);
        sxa_pkg::ADDR_FILE_IDX: st_d.fidx = PWDATA[6:0];
        sxa_pkg::ADDR_FILE_DATA: st_d.files[st_q.fidx] = PWDATA[7:0];
        default: st_d.cmd = st_q.cmd;
      endcase
    end
    // a command completes in the very cycle it is accepted
    if (exec)
    begin
      st_d.cmd = cmd_w;
      if (result_valid && to_file)
        st_d.files[cmd_w.faddr] = result;
      else if (result_valid)
        st_d.acc = result;
      if (upd_zero)
        st_d.flags.zero = (result == 8'h00);
      if (upd_carry)
      begin
        st_d.flags.carry = sub_res.carry;
        st_d.flags.half_carry_flag = sub_res.half_carry_flag;
      end
    end
  end

  // the file is reset too; costs area but keeps reads defined
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.acc <= sxa_pkg::ACC_RESET;
      st_q.flags <= sxa_pkg::FLAGS_RESET;
      st_q.fidx <= '0;
      st_q.cmd <= '0;
      st_q.rdata <= sxa_pkg::RDATA_RESET;
      st_q.err <= 1'b0;
      st_q.files <= {DEPTH{sxa_pkg::FILE_RESET}};
    end
    else
      st_q <= st_d;
  end

  // zero wait state: data was latched during setup
  assign PREADY = 1'b1;
  assign PRDATA = st_q.rdata;
  assign PSLVERR = st_q.err && PSEL && PENABLE;
  assign ACC_OUT = st_q.acc;
  assign FLAGS_OUT = st_q.flags;

  chk_lit_sub_value: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_LITERAL_SUBTRACT
    |=> st_q.acc == 8'($past(cmd_w.literal) - $past(st_q.acc)))
    else $error("literal subtract result wrong");

  chk_lit_sub_carry: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_LITERAL_SUBTRACT
    |=> st_q.flags.carry == ($past(st_q.acc) <= $past(cmd_w.literal))
        && st_q.flags.half_carry_flag
           == ($past(st_q.acc[3:0]) <= $past(cmd_w.literal[3:0])))
    else $error("literal subtract carry wrong");

  chk_reg_sub_value: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_REGISTER_SUBTRACT && !cmd_w.dest
    |=> st_q.acc == 8'($past(file_val) - $past(st_q.acc)))
    else $error("register subtract result wrong");

  chk_reg_sub_flags: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_REGISTER_SUBTRACT
    |=> st_q.flags.carry == ($past(st_q.acc) <= $past(file_val))
        && st_q.flags.half_carry_flag
           == ($past(st_q.acc[3:0]) <= $past(file_val[3:0])))
    else $error("register subtract flags wrong");

  chk_lit_xor_flags: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_LITERAL_EXCLUSIVE_OR
    |=> st_q.acc == ($past(st_q.acc) ^ $past(cmd_w.literal))
        && $stable(st_q.flags.carry) && $stable(st_q.flags.half_carry_flag))
    else $error("literal xor wrong");

  chk_swap_file: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_NIBBLE_EXCHANGE && cmd_w.dest
    |=> st_q.files[$past(cmd_w.faddr)]
        == {$past(file_val[3:0]), $past(file_val[7:4])}
        && $stable(st_q.flags))
    else $error("nibble exchange wrong");

  chk_reg_xor_file: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.op == sxa_pkg::OP_REGISTER_EXCLUSIVE_OR && cmd_w.dest
    |=> st_q.files[$past(cmd_w.faddr)] == ($past(st_q.acc) ^ $past(file_val))
        && $stable(st_q.flags.carry)
        && $stable(st_q.flags.half_carry_flag))
    else $error("register xor wrong");

  chk_dest_keeps_acc: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && cmd_w.dest && cmd_w.op != sxa_pkg::OP_LITERAL_SUBTRACT
    && cmd_w.op != sxa_pkg::OP_LITERAL_EXCLUSIVE_OR |=> $stable(st_q.acc))
    else $error("file destination touched accumulator");

  // judged on the value where it landed, not on the internal result
  chk_zero_flag: assert property (@(posedge CORE_CLK)
    disable iff (!rst_n)
    exec && upd_zero
    |=> st_q.flags.zero
        == (($past(to_file) ? st_q.files[$past(cmd_w.faddr)] : st_q.acc)
            == 8'h00))
    else $error("zero flag wrong");

endmodule
`default_nettype wire

// ==== hw/sxa_sub8.sv ====
`timescale 1ns/100ps
`default_nettype none
module sxa_sub8 #(
  parameter int unsigned W = sxa_pkg::WORD_W,
  parameter int unsigned NW = sxa_pkg::NIB_W
) (
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  output var sxa_pkg::sxa_sub_res_t res
);

  logic [W:0] full_sum;
  logic [NW:0] nib_sum;

  // two's complement: add the inverse plus one, carry out means no borrow
  always_comb
  begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
    nib_sum = {1'b0, minuend[NW-1:0]} + {1'b0, ~subtrahend[NW-1:0]}
              + {{NW{1'b0}}, 1'b1};
    res.diff = full_sum[W-1:0];
    res.carry = full_sum[W];
    res.half_carry_flag = nib_sum[NW];
  end

endmodule
`default_nettype wire

// ==== shared/sxa_pkg.sv ====
`default_nettype none
package sxa_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_FILE_IDX = 8'h0c;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h10;

  // datapath geometry
  localparam int unsigned WORD_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;

  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // destination select values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // operation codes held in the command word
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_LITERAL_SUBTRACT = 3'h1,
    OP_REGISTER_SUBTRACT = 3'h2,
    OP_LITERAL_EXCLUSIVE_OR = 3'h3,
    OP_REGISTER_EXCLUSIVE_OR = 3'h4,
    OP_NIBBLE_EXCHANGE = 3'h5
  } sxa_op_t;

  // command word, written to ADDR_CMD
  typedef struct packed {
    logic [7:0] rsv_hi;
    logic [7:0] literal;
    logic rsv_a;
    logic [6:0] faddr;
    logic [2:0] rsv_b;
    logic dest;
    logic rsv_c;
    sxa_op_t op;
  } sxa_cmd_t;

  // status flags, carry in bit 0
  typedef struct packed {
    logic zero;
    logic half_carry_flag;
    logic carry;
  } sxa_flags_t;

  localparam sxa_flags_t FLAGS_RESET = '{zero: 1'b0, half_carry_flag: 1'b0,
                                         carry: 1'b0};

  // subtractor answer
  typedef struct packed {
    logic [7:0] diff;
    logic carry;
    logic half_carry_flag;
  } sxa_sub_res_t;

endpackage
`default_nettype wire

// ==== verification/sxa_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// compare with case equality so an unknown never passes
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module testbench;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [7:0] ACC_OUT;
  sxa_pkg::sxa_flags_t FLAGS_OUT;
  int error_cnt = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;

  sxa_alu sxa_alu_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .ACC_OUT(ACC_OUT), .FLAGS_OUT(FLAGS_OUT));

  // 100 mhz core clock
  always #5 CORE_CLK = ~CORE_CLK;

  // one apb transfer; an idle cycle follows so strobes never collide
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n >= 20)
      error_cnt++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  // load operands, issue one command, compare against the bench's own model
  task automatic do_case(input logic [2:0] op, input logic dest,
    input logic [6:0] fa, input logic [7:0] lit, input logic [7:0] acc,
    input logic [7:0] fv, input logic [2:0] st);
    sxa_pkg::sxa_cmd_t c;
    logic [7:0] o, r, ea, ef;
    logic [2:0] efl;
    logic lop, hit;
    c = '0;
    c.op = sxa_pkg::sxa_op_t'(op);
    c.dest = dest;
    c.faddr = fa;
    c.literal = lit;
    lop = (op == sxa_pkg::OP_LITERAL_SUBTRACT) ||
          (op == sxa_pkg::OP_LITERAL_EXCLUSIVE_OR);
    o = lop ? lit : fv;
    ea = acc;
    ef = fv;
    efl = st;
    hit = 1'b1;
    r = 8'h00;
    case (op)
      sxa_pkg::OP_LITERAL_SUBTRACT, sxa_pkg::OP_REGISTER_SUBTRACT:
      begin
        r = o - acc;
        efl = {r == 8'h00, acc[3:0] <= o[3:0], acc <= o};
      end
      sxa_pkg::OP_LITERAL_EXCLUSIVE_OR, sxa_pkg::OP_REGISTER_EXCLUSIVE_OR:
      begin
        r = acc ^ o;
        efl[2] = (r == 8'h00);
      end
      sxa_pkg::OP_NIBBLE_EXCHANGE: r = {fv[3:0], fv[7:4]};
      default: hit = 1'b0;
    endcase
    // literal forms always land in the accumulator
    if (hit && (lop || dest == sxa_pkg::DEST_ACC))
      ea = r;
    else if (hit)
      ef = r;
    apb(1'b1, sxa_pkg::ADDR_ACC, {24'h000000, acc});
    apb(1'b1, sxa_pkg::ADDR_STATUS, {29'h0, st});
    apb(1'b1, sxa_pkg::ADDR_FILE_IDX, {25'h0, fa});
    apb(1'b1, sxa_pkg::ADDR_FILE_DATA, {24'h000000, fv});
    apb(1'b1, sxa_pkg::ADDR_CMD, c);
    `CHK(ACC_OUT, ea)
    `CHK(FLAGS_OUT, efl)
    apb(1'b0, sxa_pkg::ADDR_FILE_DATA, 32'h0000_0000);
    `CHK(rd, {24'h000000, ef})
    `CHK(err, 1'b0)
    apb(1'b0, sxa_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(rd, {29'h0, efl})
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    `CHK(ACC_OUT, 8'h00)
    `CHK(FLAGS_OUT, 3'h0)
    apb(1'b0, sxa_pkg::ADDR_CMD, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // unmapped place: write dropped, read zero, error flagged
    apb(1'b1, 8'h14, 32'hffff_ffff);
    `CHK(err, 1'b1)
    `CHK(ACC_OUT, 8'h00)
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(err, 1'b1)
    do_case(3'h1, 1'b0, 7'h00, 8'h05, 8'h05, 8'h11, 3'h0);
    do_case(3'h1, 1'b1, 7'h01, 8'h20, 8'h1f, 8'haa, 3'h7);
    do_case(3'h1, 1'b0, 7'h02, 8'h05, 8'h06, 8'h33, 3'h7);
    do_case(3'h2, 1'b0, 7'h00, 8'h00, 8'h01, 8'h10, 3'h0);
    do_case(3'h2, 1'b1, 7'h7f, 8'h00, 8'h80, 8'h80, 3'h0);
    do_case(3'h2, 1'b1, 7'h03, 8'h00, 8'h01, 8'h00, 3'h7);
    do_case(3'h2, 1'b0, 7'h04, 8'h00, 8'h18, 8'h21, 3'h0);
    do_case(3'h3, 1'b0, 7'h05, 8'h5a, 8'h5a, 8'h44, 3'h3);
    do_case(3'h3, 1'b1, 7'h06, 8'hf0, 8'h0f, 8'h55, 3'h4);
    do_case(3'h4, 1'b0, 7'h40, 8'h00, 8'h3c, 8'hc3, 3'h7);
    do_case(3'h4, 1'b1, 7'h7f, 8'h00, 8'h55, 8'h55, 3'h0);
    do_case(3'h5, 1'b0, 7'h08, 8'h00, 8'h99, 8'ha5, 3'h5);
    do_case(3'h5, 1'b1, 7'h7f, 8'h00, 8'h99, 8'h3c, 3'h2);
    do_case(3'h0, 1'b1, 7'h09, 8'h12, 8'h34, 8'h56, 3'h6);
    do_case(3'h7, 1'b1, 7'h0a, 8'h12, 8'h77, 8'h56, 3'h1);
    // the command word reads back as last written, unknown code included
    apb(1'b0, sxa_pkg::ADDR_CMD, 32'h0000_0000);
    `CHK(rd, 32'h0012_0a17)
    // second reset in mid-run clears the accumulator and flags
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    `CHK(ACC_OUT, 8'h00)
    `CHK(FLAGS_OUT, 3'h0)
    RESET_N <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    // file word 0 was loaded earlier; reset must clear it again
    apb(1'b0, sxa_pkg::ADDR_FILE_DATA, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
